//--- common/two_pkg.sv
// package: constants for the timer waveform output block
package two_pkg;
    localparam int          TWO_WIDTH      = 8;
    localparam logic [7:0]  TWO_MAX        = 8'hFF;
    localparam logic [7:0]  TWO_BOTTOM     = 8'h00;
    localparam logic [7:0]  TWO_CNT_RESET  = 8'h00;
    localparam logic [7:0]  TWO_OCR_RESET  = 8'h00;
    localparam logic        TWO_WAVE_RESET = 1'b0;
    localparam logic [2:0]  TWO_WGM_NORMAL = 3'h0;
    localparam logic [2:0]  TWO_WGM_CTC    = 3'h2;
    localparam logic [2:0]  TWO_WGM_FAST   = 3'h3;
    localparam logic [2:0]  TWO_WGM_FASTA  = 3'h7;
    localparam logic [1:0]  TWO_COM_OFF    = 2'h0;
    localparam logic [1:0]  TWO_COM_TOGGLE = 2'h1;
    localparam logic [1:0]  TWO_COM_CLEAR  = 2'h2;
    localparam logic [1:0]  TWO_COM_SET    = 2'h3;
    localparam int          TWO_WGM_B2_POS = 2;
    localparam int          TWO_CHAN_A     = 0;
    localparam int          TWO_CHAN_B     = 1;
    typedef enum logic [1:0] {TWO_ACT_NONE, TWO_ACT_SET, TWO_ACT_CLR, TWO_ACT_TGL} two_act_t;
endpackage

//--- hdl/two_pin_mux.sv
// pin override: waveform output replaces port value when mode field nonzero
`timescale 1ns/1ps
module two_pin_mux (
    // configuration
    input  wire logic [1:0] i_com,
    input  wire logic       i_port_value,
    input  wire logic       i_port_dir,
    // waveform
    input  wire logic       i_wave,
    // pin
    output logic            o_pin_out,
    output logic            o_pin_oe
);
    import two_pkg::*;
    // override is independent of the waveform mode
    assign o_pin_out = (i_com != TWO_COM_OFF) ? i_wave : i_port_value; // RULE_02
    assign o_pin_oe  = i_port_dir; // RULE_03
endmodule

//--- hdl/two_timer_wave.sv
// 8-bit timer counter with compare match waveform outputs
// Behaviour
// RULE_01: reset clears both waveform output bits
// RULE_02: nonzero mode field routes waveform to pin
// RULE_03: pin direction bit alone enables driver
// RULE_04: mode field zero leaves output unchanged
// RULE_05: new mode acts at next match; force immediate
// RULE_06: output mode fields never alter counting
// RULE_07: normal mode increments, wraps FF to 00
// RULE_08: normal overflow flag set when counter zero
// RULE_09: counter writable anytime in normal mode
// RULE_10: clear-on-match mode clears counter at compare A
// RULE_11: clear-on-match sets compare flag A at top
// RULE_12: clear-on-match compare A written directly, unbuffered
// RULE_13: clear-on-match toggle mode toggles output A
// RULE_14: toggle frequency follows prescale and compare value
// RULE_15: clear-on-match overflow on wrap max to zero
// RULE_16: fast PWM counts bottom to top, restarts
// RULE_17: fast PWM clear/set at match, opposite at bottom
// RULE_18: fast PWM clears cycle after reaching top
// RULE_19: fast PWM overflow flag set at top
// RULE_20: fast PWM toggle only channel A, mode bit two
// RULE_21: fast PWM period is 256 timer clocks; mode 7 uses compare A plus one
// RULE_22: compare extremes give spike or constant level
// RULE_23: match sets compare flag next timer clock
// RULE_24: force updates output, no flag, no clear
// RULE_25: counter write blocks matches next timer clock
// RULE_26: PWM compare writes buffered, updated at bottom
// RULE_27: logic advances only on timer clock enable
`timescale 1ns/1ps
module two_timer_wave #(
    parameter int WIDTH = two_pkg::TWO_WIDTH
) (
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    // prescaled timer clock enable
    input  wire logic                 i_tick,
    // mode control
    input  wire logic [2:0]           i_waveform_mode,
    input  wire logic [1:0]           i_compare_output_mode_a,
    input  wire logic [1:0]           i_compare_output_mode_b,
    input  wire logic                 i_force_compare_strobe_a,
    input  wire logic                 i_force_compare_strobe_b,
    // counter and compare register writes
    input  wire logic                 i_counter_wr,
    input  wire logic [WIDTH-1:0]     i_counter_wdata,
    input  wire logic                 i_compare_a_wr,
    input  wire logic                 i_compare_b_wr,
    input  wire logic [WIDTH-1:0]     i_compare_wdata,
    // flag clears (write one)
    input  wire logic                 i_overflow_clr,
    input  wire logic                 i_compare_a_clr,
    input  wire logic                 i_compare_b_clr,
    // port values and directions
    input  wire logic [1:0]           i_port_value,
    input  wire logic [1:0]           i_port_dir,
    // status
    output logic [WIDTH-1:0]          o_counter_value,
    output logic [WIDTH-1:0]          o_compare_register_a,
    output logic [WIDTH-1:0]          o_compare_register_b,
    output logic                      o_overflow_flag,
    output logic                      o_compare_flag_a,
    output logic                      o_compare_flag_b,
    output logic [1:0]                o_waveform_output,
    // pins
    output logic [1:0]                o_pin_out,
    output logic [1:0]                o_pin_oe
);
    import two_pkg::*;

    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;
    logic [WIDTH-1:0] ocr_reg [2];
    logic [WIDTH-1:0] ocr_buf_reg [2];
    logic [1:0]       wave_reg;
    logic [1:0]       match_reg;
    logic             block_reg;
    logic             tov_reg;
    logic [1:0]       ocf_reg;
    logic             is_pwm;
    logic             top_ocra;
    logic [WIDTH-1:0] top_val;
    logic             at_top;
    logic             at_bottom_next;
    logic [1:0]       match;
    logic [1:0]       com [2];
    logic [1:0]       force_stb;
    logic [1:0]       ocr_wr;
    logic [1:0]       flag_clr;
    logic             tov_set;

    // modes with buffered compare registers
    function automatic logic mode_is_pwm(input logic [2:0] m);
        return (m == TWO_WGM_FAST) || (m == TWO_WGM_FASTA);
    endfunction

    // translate mode field into the action taken at a match
    function automatic two_act_t match_action(input logic [1:0] c, input logic pwm,
                                              input logic chan_a, input logic b2);
        two_act_t a;
        a = TWO_ACT_NONE;
        case (c)
            TWO_COM_OFF: a = TWO_ACT_NONE;
            TWO_COM_TOGGLE: begin
                if (!pwm || (chan_a && b2)) begin
                    a = TWO_ACT_TGL;
                end
            end
            TWO_COM_CLEAR: a = TWO_ACT_CLR;
            default: a = TWO_ACT_SET;
        endcase
        return a;
    endfunction

    assign com[TWO_CHAN_A] = i_compare_output_mode_a;
    assign com[TWO_CHAN_B] = i_compare_output_mode_b;
    assign force_stb = {i_force_compare_strobe_b, i_force_compare_strobe_a};
    assign ocr_wr    = {i_compare_b_wr, i_compare_a_wr};
    assign flag_clr  = {i_compare_b_clr, i_compare_a_clr};

    // counting depends only on the waveform mode field
    assign is_pwm   = mode_is_pwm(i_waveform_mode); // RULE_06
    assign top_ocra = (i_waveform_mode == TWO_WGM_CTC) || (i_waveform_mode == TWO_WGM_FASTA);
    assign top_val  = top_ocra ? ocr_reg[TWO_CHAN_A] : TWO_MAX; // RULE_16
    assign at_top   = (cnt_reg == top_val);

    // comparators; a counter write blocks matches for one timer clock
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cmp
            assign match[g] = (cnt_reg == ocr_reg[g]) && !block_reg; // RULE_25
        end
    endgenerate

    // counter next value
    always_comb begin
        cnt_next = cnt_reg + WIDTH'(1); // RULE_07
        if (top_ocra && at_top) begin
            cnt_next = TWO_BOTTOM; // RULE_10 RULE_18
        end else if (is_pwm && at_top) begin
            cnt_next = TWO_BOTTOM; // RULE_16 RULE_21
        end
    end
    assign at_bottom_next = i_tick && !i_counter_wr && (cnt_next == TWO_BOTTOM);

    // counter: cpu write has priority over counting
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_reg <= TWO_CNT_RESET;
        end else if (i_counter_wr) begin
            cnt_reg <= i_counter_wdata; // RULE_09
        end else if (i_tick) begin
            cnt_reg <= cnt_next; // RULE_27
        end
    end

    // blocking window lasts until the next timer clock, even if stopped
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            block_reg <= 1'b0;
        end else if (i_counter_wr) begin
            block_reg <= 1'b1; // RULE_25
        end else if (i_tick) begin
            block_reg <= 1'b0;
        end
    end

    // compare registers: direct in non-PWM, buffered in PWM until bottom
    generate
        for (g = 0; g < 2; g++) begin : g_ocr
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    ocr_reg[g]     <= TWO_OCR_RESET;
                    ocr_buf_reg[g] <= TWO_OCR_RESET;
                end else begin
                    if (ocr_wr[g]) begin
                        ocr_buf_reg[g] <= i_compare_wdata;
                    end
                    if (!is_pwm && ocr_wr[g]) begin
                        ocr_reg[g] <= i_compare_wdata; // RULE_12 RULE_26
                    end else if (is_pwm && at_bottom_next) begin
                        ocr_reg[g] <= ocr_wr[g] ? i_compare_wdata : ocr_buf_reg[g]; // RULE_26
                    end else if (!is_pwm) begin
                        ocr_reg[g] <= ocr_buf_reg[g];
                    end
                end
            end
        end
    endgenerate

    // match seen at one timer clock raises its flag at the next
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            match_reg <= 2'b00;
        end else if (i_tick) begin
            match_reg <= match; // RULE_23
        end
    end

    // compare flags: set wins over clear
    generate
        for (g = 0; g < 2; g++) begin : g_ocf
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    ocf_reg[g] <= 1'b0;
                end else if (i_tick && match_reg[g]) begin
                    ocf_reg[g] <= 1'b1; // RULE_11 RULE_23
                end else if (flag_clr[g]) begin
                    ocf_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // overflow: wrap to zero in normal and ctc, reaching top in fast pwm
    assign tov_set = i_tick && !i_counter_wr &&
                     (is_pwm ? at_top : (cnt_reg == TWO_MAX)); // RULE_08 RULE_15 RULE_19

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            tov_reg <= 1'b0;
        end else if (tov_set) begin
            tov_reg <= 1'b1; // RULE_08
        end else if (i_overflow_clr) begin
            tov_reg <= 1'b0;
        end
    end

    // waveform bits; mode fields read live so a change acts at next match
    generate
        for (g = 0; g < 2; g++) begin : g_wave
            two_act_t act;
            logic     do_match;
            logic     do_force;
            logic     do_bottom;
            assign act = match_action(com[g], is_pwm, g == TWO_CHAN_A,
                                      i_waveform_mode[TWO_WGM_B2_POS]); // RULE_13 RULE_20
            assign do_match  = i_tick && match[g]; // RULE_05 RULE_27
            assign do_force  = !is_pwm && force_stb[g]; // RULE_24
            assign do_bottom = is_pwm && at_bottom_next &&
                               (com[g] == TWO_COM_CLEAR || com[g] == TWO_COM_SET);
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    wave_reg[g] <= TWO_WAVE_RESET; // RULE_01
                end else if (do_match || do_force) begin
                    // none keeps the bit: mode zero does nothing
                    case (act)
                        TWO_ACT_SET: wave_reg[g] <= 1'b1; // RULE_17
                        TWO_ACT_CLR: wave_reg[g] <= 1'b0; // RULE_17
                        TWO_ACT_TGL: wave_reg[g] <= !wave_reg[g]; // RULE_13 RULE_14
                        default: wave_reg[g] <= wave_reg[g]; // RULE_04
                    endcase
                end else if (do_bottom) begin
                    // a match at top still wins above: gives the constant level
                    wave_reg[g] <= (com[g] == TWO_COM_CLEAR); // RULE_17 RULE_22
                end
            end

            two_pin_mux u_pin (
                .i_com        (com[g]),
                .i_port_value (i_port_value[g]),
                .i_port_dir   (i_port_dir[g]),
                .i_wave       (wave_reg[g]),
                .o_pin_out    (o_pin_out[g]),
                .o_pin_oe     (o_pin_oe[g])
            );
        end
    endgenerate

    assign o_counter_value      = cnt_reg;
    assign o_compare_register_a = ocr_reg[TWO_CHAN_A];
    assign o_compare_register_b = ocr_reg[TWO_CHAN_B];
    assign o_overflow_flag      = tov_reg;
    assign o_compare_flag_a     = ocf_reg[TWO_CHAN_A];
    assign o_compare_flag_b     = ocf_reg[TWO_CHAN_B];
    assign o_waveform_output    = wave_reg;

    // assertions
    a_reset_wave: assert property (@(posedge i_mclk)
        i_rst |=> wave_reg == 2'b00) // RULE_01
        else $error("waveform bits not cleared by reset");
    a_pin_override: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_compare_output_mode_a != TWO_COM_OFF) |-> o_pin_out[0] == wave_reg[0]) // RULE_02
        else $error("pin A not driven from waveform");
    a_pin_dir: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_pin_oe == i_port_dir) // RULE_03
        else $error("pin enable not from direction bit");
    a_com_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_compare_output_mode_b == TWO_COM_OFF && !is_pwm) |=> $stable(wave_reg[1])) // RULE_04
        else $error("output B changed with mode zero");
    a_normal_wrap: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_waveform_mode == TWO_WGM_NORMAL && i_tick && !i_counter_wr && cnt_reg == TWO_MAX)
        |=> cnt_reg == TWO_BOTTOM && tov_reg) // RULE_07
        else $error("normal wrap or overflow flag wrong");
    a_ctc_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_waveform_mode == TWO_WGM_CTC && i_tick && !i_counter_wr && at_top)
        |=> cnt_reg == TWO_BOTTOM) // RULE_10
        else $error("ctc did not clear at compare A");
    // flag may only rise on a timer clock edge, one tick after the match
    a_flag_delay: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!i_tick && !ocf_reg[0]) |=> !ocf_reg[0]) // RULE_23
        else $error("compare flag set before next timer clock");
    a_write_block: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_counter_wr |=> match == 2'b00) // RULE_25
        else $error("match not blocked after counter write");
    a_hold_idle: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!i_tick && !i_counter_wr) |=> $stable(cnt_reg)) // RULE_27
        else $error("counter moved without timer clock");
    a_force_noflag: assert property (@(posedge i_mclk) disable iff (i_rst)
        (force_stb[0] && !match_reg[0] && !ocf_reg[0]) |=> !ocf_reg[0]) // RULE_24
        else $error("force set compare flag");
    c_ctc_toggle: cover property (@(posedge i_mclk)
        i_waveform_mode == TWO_WGM_CTC && i_compare_output_mode_a == TWO_COM_TOGGLE
        && $changed(wave_reg[0]));
    c_fast_pwm: cover property (@(posedge i_mclk)
        i_waveform_mode == TWO_WGM_FAST && $fell(wave_reg[1]));
    c_overflow: cover property (@(posedge i_mclk) $rose(tov_reg));
    c_spike: cover property (@(posedge i_mclk)
        is_pwm && ocr_reg[TWO_CHAN_A] == TWO_BOTTOM && $rose(wave_reg[0]));
    c_force: cover property (@(posedge i_mclk)
        !is_pwm && force_stb[0] && i_compare_output_mode_a != TWO_COM_OFF);
endmodule

//--- test/two_pin_load.sv
// pin load model: external circuit with pull-ups on both waveform pins
`timescale 1ns/1ps
module two_pin_load (
    // pins from the device
    input  wire logic [1:0] i_pin_out,
    input  wire logic [1:0] i_pin_oe,
    // level seen by the external circuit
    output logic [1:0]      o_level
);
    // an undriven pin goes to the pull-up, it never keeps the last value
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            o_level[i] = i_pin_oe[i] ? i_pin_out[i] : 1'b1;
        end
    end
endmodule

//--- test/tb_two_timer_wave.sv
// testbench for the timer waveform output block
`timescale 1ns/1ps
module tb_two_timer_wave;
    import two_pkg::*;
    logic       i_mclk = 0;
    logic       i_rst = 1;
    logic       tick = 0;
    logic [2:0] wgm = TWO_WGM_NORMAL;
    logic [1:0] com_a = TWO_COM_OFF;
    logic [1:0] com_b = TWO_COM_OFF;
    logic       frc_a = 0;
    logic       cnt_wr = 0;
    logic [7:0] wdata = 8'h00;
    logic       cmp_a_wr = 0;
    logic       cmp_b_wr = 0;
    logic       flg_clr = 0;
    logic [1:0] port_val = 2'h2;
    logic [1:0] port_dir = 2'h1;
    logic [7:0] cnt, ocra, ocrb, b;
    logic       ovf, cfa, cfb;
    logic [1:0] wave, pin, oe, lvl, w2;
    int         err_count = 0;
    int         checks = 0;
    int         tick_div = 1;
    int         cyc = 0;
    int         n;
    int         h;

    always #12.5 i_mclk = ~i_mclk;

    // tick_div of 0 stops the timer; ceiling is well above the whole run
    always @(negedge i_mclk) begin
        cyc <= cyc + 1;
        tick <= (tick_div != 0) && (cyc % tick_div == 0);
        if (cyc > 20000) begin
            err_count++;
            end_sim();
        end
    end

    two_timer_wave two_timer_wave_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_tick(tick), .i_waveform_mode(wgm),
        .i_compare_output_mode_a(com_a), .i_compare_output_mode_b(com_b),
        .i_force_compare_strobe_a(frc_a), .i_force_compare_strobe_b(frc_a),
        .i_counter_wr(cnt_wr), .i_counter_wdata(wdata), .i_compare_a_wr(cmp_a_wr),
        .i_compare_b_wr(cmp_b_wr), .i_compare_wdata(wdata), .i_overflow_clr(flg_clr),
        .i_compare_a_clr(flg_clr), .i_compare_b_clr(flg_clr), .i_port_value(port_val),
        .i_port_dir(port_dir), .o_counter_value(cnt), .o_compare_register_a(ocra),
        .o_compare_register_b(ocrb), .o_overflow_flag(ovf), .o_compare_flag_a(cfa),
        .o_compare_flag_b(cfb), .o_waveform_output(wave), .o_pin_out(pin),
        .o_pin_oe(oe));

    two_pin_load two_pin_load_inst (.i_pin_out(pin), .i_pin_oe(oe), .o_level(lvl));

    task automatic end_sim();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_byte(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic chk_num(input int got, input int exp);
        checks++;
        if (got != exp) begin
            err_count++;
            $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(negedge i_mclk);
    endtask

    // each driver task lets an edge pass first, so no strobe is set twice at once
    task automatic wr_cnt(input logic [7:0] v);
        step(1);
        cnt_wr = 1;
        wdata = v;
        step(1);
        cnt_wr = 0;
    endtask

    task automatic wr_cmp(input logic sel_b, input logic [7:0] v);
        step(1);
        cmp_a_wr = !sel_b;
        cmp_b_wr = sel_b;
        wdata = v;
        step(1);
        cmp_a_wr = 0;
        cmp_b_wr = 0;
    endtask

    task automatic clr_flags();
        step(1);
        flg_clr = 1;
        step(1);
        flg_clr = 0;
    endtask

    task automatic frc();
        step(1);
        frc_a = 1;
        step(1);
        frc_a = 0;
    endtask

    task automatic wait_wave(input int i, output int k);
        logic w;
        w = wave[i];
        k = 0;
        while (wave[i] === w && k < 2000) begin
            step(1);
            k++;
        end
    endtask

    task automatic wait_zero();
        int k;
        k = 0;
        step(1);
        while (cnt !== 8'h00 && k < 2000) begin
            step(1);
            k++;
        end
    endtask

    task automatic count_hi(input int i, output int hc);
        hc = 0;
        repeat (256) begin
            step(1);
            hc += (wave[i] === 1'b1);
        end
    endtask

    initial begin
        step(12);
        i_rst = 0;
        chk_byte({wave, ovf, cfa, cfb, cnt}, 13'h0);
        chk_byte({pin, oe, lvl}, {port_val, port_dir, 2'b10});
        step(2);
        // the match at count zero right after reset has raised the flag
        clr_flags();
        com_a = TWO_COM_SET;
        b = cnt;
        frc();
        chk_byte({wave[0], cfa, pin[0], lvl[0]}, 4'hB);
        chk_byte(cnt, 8'(b + 8'h02));
        com_a = TWO_COM_OFF;
        frc();
        chk_byte({wave[0], pin[0]}, 2'b10);
        com_a = TWO_COM_CLEAR;
        step(2);
        chk_byte(wave[0], 1'b1);
        port_dir = 2'h0;
        step(1);
        chk_byte({oe, lvl[0]}, 3'b001);
        port_dir = 2'h1;
        clr_flags();
        wr_cnt(8'hFD);
        chk_byte(cnt, 8'hFD);
        step(2);
        chk_byte({cnt, ovf}, 9'h1FE);
        step(1);
        chk_byte({cnt, ovf}, 9'h001);
        step(1);
        chk_byte({wave[0], cfa}, 2'b00);
        step(1);
        chk_byte(cfa, 1'b1);
        clr_flags();
        com_a = TWO_COM_TOGGLE;
        wr_cmp(0, 8'h10);
        wr_cnt(8'h10);
        step(3);
        chk_byte({wave[0], cfa}, 2'b00);
        wr_cnt(8'h0E);
        step(3);
        chk_byte({wave[0], cfa}, 2'b10);
        step(1);
        chk_byte(cfa, 1'b1);
        tick_div = 0;
        wr_cnt(8'h33);
        step(20);
        chk_byte(cnt, 8'h33);
        wgm = TWO_WGM_CTC;
        // half period of the toggle is prescale times one plus compare value
        for (int j = 0; j < 2; j++) begin
            tick_div = j ? 1 : 8;
            wr_cmp(0, j ? 8'h00 : 8'h03);
            wr_cnt(8'h00);
            clr_flags();
            wait_wave(0, n);
            wait_wave(0, n);
            chk_num(n, j ? 1 : 32);
            chk_byte({cfa, cnt <= ocra}, 2'b11);
        end
        wr_cmp(0, 8'h03);
        clr_flags();
        wr_cnt(8'hFD);
        step(2);
        chk_byte(cnt, 8'hFF);
        step(1);
        chk_byte({cnt, ovf}, 9'h001);
        wgm = TWO_WGM_FAST;
        com_a = TWO_COM_CLEAR;
        com_b = TWO_COM_SET;
        wr_cnt(8'h10);
        wr_cmp(0, 8'h40);
        chk_byte(ocra, 8'h03);
        wr_cmp(1, 8'h80);
        wait_zero();
        step(1);
        chk_byte({ocra, ocrb}, 16'h4080);
        for (int j = 0; j < 2; j++) begin
            wr_cmp(0, j ? 8'h00 : 8'h40);
            wait_zero();
            clr_flags();
            wait_zero();
            count_hi(0, n);
            chk_num(n, j ? 1 : 65);
            count_hi(1, h);
            chk_num(h, 127);
            chk_byte(ovf, 1'b1);
            chk_byte(cfb, 1'b1);
        end
        com_a = TWO_COM_TOGGLE;
        com_b = TWO_COM_TOGGLE;
        step(1);
        w2 = wave;
        frc();
        step(300);
        chk_byte(wave, w2);
        wgm = TWO_WGM_FASTA;
        wr_cmp(0, 8'h09);
        wait_zero();
        wait_zero();
        wait_wave(0, n);
        wait_wave(0, n);
        chk_num(n, 10);
        chk_byte({cnt <= 8'h09, wave[1]}, {1'b1, w2[1]});
        end_sim();
    end
endmodule
